// file: hw/ddc_bind_ctrl.sv
/*
 * Channel binding, rational divisor and oscillator sync control registers.
 * Assumes a byte register port with one-cycle strobes and one-cycle read latency,
 * and converter samples, SYSREF and LMFC marks synchronous to the clock.
 */
// Decided for this implementation: strobed register access.
`default_nettype none

// Notes on behaviour
// - Channel B source: 0 converter A, 1 B
// - Channel A source: 0 converter A, 1 B
// - Bound converter powered down powers channel down
// - Sixteen-bit divisor, reset zero, all presets
// - Lane-alignment bit: init on starting LMFC edge
// - Write 0 then 1 arms SYSREF init
// - After SYSREF init, ignore edges until rearmed
module ddc_bind_ctrl (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // Register port.
    input wire logic [9:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Converter sample streams.
    input wire logic [ddc_bind_pkg::sample_width-1:0] i_conv_a_sample,
    input wire logic i_conv_a_valid,
    input wire logic [ddc_bind_pkg::sample_width-1:0] i_conv_b_sample,
    input wire logic i_conv_b_valid,
    // Converter power-down controls and link status.
    input wire logic i_converter_a_powerdown,
    input wire logic i_converter_b_powerdown,
    input wire logic i_serial_link_enable,
    // Link timing events.
    input wire logic i_lmfc_ila_start,
    input wire logic i_sysref,
    // Digital channel outputs.
    output ddc_bind_pkg::dig_chan_t o_dig_a,
    output ddc_bind_pkg::dig_chan_t o_dig_b,
    output logic o_link_a_powerdown,
    output logic o_link_b_powerdown,
    // Oscillator controls.
    output logic [15:0] o_rational_divisor,
    output logic o_phase_init
);

    logic [15:0] rational_divisor;
    logic [7:0] oscillator_sync_control;
    logic [7:0] channel_binding;
    logic sysref_init;
    logic sysref_armed;

    // Address decode.
    wire logic hit_div_lo;
    wire logic hit_div_hi;
    wire logic hit_sync;
    wire logic hit_bind;
    wire logic wr_sync;
    wire logic [7:0] next_rdata;
    assign hit_div_lo = (i_addr == ddc_bind_pkg::rational_divisor_lo_offset);
    assign hit_div_hi = (i_addr == ddc_bind_pkg::rational_divisor_hi_offset);
    assign hit_sync = (i_addr == ddc_bind_pkg::oscillator_sync_control_offset);
    assign hit_bind = (i_addr == ddc_bind_pkg::channel_binding_offset);
    assign wr_sync = i_wr & hit_sync;

    // Read multiplexer; unmapped addresses read zero.
    assign next_rdata = hit_div_lo ? rational_divisor[7:0] :
                        hit_div_hi ? rational_divisor[15:8] :
                        hit_sync ? oscillator_sync_control :
                        hit_bind ? channel_binding : 8'h00;

    // Power-down of whichever converter a digital channel is bound to.
    function automatic logic bound_powerdown(
        input logic sel,
        input logic pd_conv_a,
        input logic pd_conv_b
    );
        return sel ? pd_conv_b : pd_conv_a;
    endfunction : bound_powerdown

    // Source selection and power-down decode.
    wire logic digital_a_source_select;
    wire logic digital_b_source_select;
    wire logic phase_init_on_lane_alignment;
    wire logic next_pd_a;
    wire logic next_pd_b;
    assign digital_a_source_select = channel_binding[ddc_bind_pkg::bind_a_bit];
    assign digital_b_source_select = channel_binding[ddc_bind_pkg::bind_b_bit];
    assign phase_init_on_lane_alignment = oscillator_sync_control[ddc_bind_pkg::sync_ila_bit];
    assign next_pd_a = bound_powerdown(digital_a_source_select, i_converter_a_powerdown,
                                       i_converter_b_powerdown);
    assign next_pd_b = bound_powerdown(digital_b_source_select, i_converter_a_powerdown,
                                       i_converter_b_powerdown);

    // Picks the stream of the selected converter, muted when powered down.
    function automatic ddc_bind_pkg::dig_chan_t route(
        input logic sel,
        input logic pd,
        input logic [ddc_bind_pkg::sample_width-1:0] sa,
        input logic va,
        input logic [ddc_bind_pkg::sample_width-1:0] sb,
        input logic vb
    );
        ddc_bind_pkg::dig_chan_t r;
        r.sample = pd ? '0 : (sel ? sb : sa);
        r.valid = pd ? 1'b0 : (sel ? vb : va);
        r.powerdown = pd;
        return r;
    endfunction : route

    // Register writes; the binding bits are taken as written, software owns sequencing.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            rational_divisor <= ddc_bind_pkg::rational_divisor_reset;
            oscillator_sync_control <= ddc_bind_pkg::oscillator_sync_control_reset;
            channel_binding <= ddc_bind_pkg::channel_binding_reset;
        end else if (i_wr) begin
            if (hit_div_lo) begin
                rational_divisor[7:0] <= i_wdata;
            end
            if (hit_div_hi) begin
                rational_divisor[15:8] <= i_wdata;
            end
            if (hit_sync) begin
                oscillator_sync_control <= i_wdata;
            end
            if (hit_bind) begin
                channel_binding <= i_wdata;
            end
        end
    end

    // Read data stands in the cycle after the read strobe only.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd ? next_rdata : 8'h00;
        end
    end

    // Arming sequence for SYSREF phase initialisation.
    sysref_arm u_sysref_arm (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_wr_next(wr_sync),
        .i_wr_value(i_wdata[ddc_bind_pkg::sync_next_bit]),
        .i_sysref(i_sysref),
        .o_init(sysref_init),
        .o_armed(sysref_armed)
    );

    // Datapath routing and oscillator strobes, all registered.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_dig_a <= '0;
            o_dig_b <= '0;
            o_link_a_powerdown <= 1'b0;
            o_link_b_powerdown <= 1'b0;
            o_rational_divisor <= ddc_bind_pkg::rational_divisor_reset;
            o_phase_init <= 1'b0;
        end else begin
            o_dig_a <= route(digital_a_source_select, next_pd_a, i_conv_a_sample,
                             i_conv_a_valid, i_conv_b_sample, i_conv_b_valid);
            o_dig_b <= route(digital_b_source_select, next_pd_b, i_conv_a_sample,
                             i_conv_a_valid, i_conv_b_sample, i_conv_b_valid);
            o_link_a_powerdown <= next_pd_a;
            o_link_b_powerdown <= next_pd_b;
            o_rational_divisor <= rational_divisor;
            o_phase_init <= (phase_init_on_lane_alignment && i_lmfc_ila_start)
                || sysref_init;
        end
    end

    // Steps of the two phase initialisation paths.
    sequence s_ila_mark;
        phase_init_on_lane_alignment && i_lmfc_ila_start;
    endsequence

    sequence s_armed_edge;
        sysref_armed && $rose(i_sysref)
            && !(wr_sync && !i_wdata[ddc_bind_pkg::sync_next_bit]);
    endsequence

    sequence s_sysref_strobe;
        sysref_init ##1 o_phase_init;
    endsequence

    // Lane-alignment edge with the bit set gives the strobe next cycle.
    chk_ila_phase_init: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        s_ila_mark |=> o_phase_init)
        else $error("lane alignment init missed");

    // With the bit clear a lane-alignment mark alone gives no strobe.
    chk_ila_off: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (!phase_init_on_lane_alignment && i_lmfc_ila_start && !sysref_init) |=> !o_phase_init)
        else $error("lane alignment init while disabled");

    // Strobe only with a cause one cycle earlier.
    chk_init_cause: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        o_phase_init |-> $past(phase_init_on_lane_alignment && i_lmfc_ila_start)
            || $past(sysref_init))
        else $error("phase init without cause");

    // An armed SYSREF rising edge runs through the strobe to the output.
    chk_sysref_fires: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        s_armed_edge |=> s_sysref_strobe)
        else $error("armed sysref edge lost");

    // Firing disarms, so later edges are not taken.
    chk_sysref_disarms: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        s_armed_edge |=> !sysref_armed)
        else $error("still armed after sysref init");

    // An edge while not armed gives no strobe.
    chk_sysref_ignored: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        ($rose(i_sysref) && !sysref_armed) |=> !sysref_init)
        else $error("sysref init while disarmed");

    // A SYSREF init strobe needs the armed state before it.
    chk_sysref_gate: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        sysref_init |-> $past(sysref_armed))
        else $error("sysref init while not armed");

    // Writing a 0 to the arming bit always disarms.
    chk_disarm_write: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (wr_sync && !i_wdata[ddc_bind_pkg::sync_next_bit]) |=> !sysref_armed)
        else $error("armed after a zero write");

    // Armed stays armed until an edge or a write.
    chk_armed_holds: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (sysref_armed && !$rose(i_sysref) && !wr_sync) |=> sysref_armed)
        else $error("arming lost without cause");

    // Channel B follows its select bit.
    chk_bind_b_route: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (!next_pd_b && digital_b_source_select) |=> o_dig_b.sample == $past(i_conv_b_sample))
        else $error("channel b routing wrong");

    chk_bind_b_from_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (!next_pd_b && !digital_b_source_select) |=> o_dig_b.sample == $past(i_conv_a_sample))
        else $error("channel b from a wrong");

    // Channel A follows its select bit.
    chk_bind_a_route: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (!next_pd_a && !digital_a_source_select) |=> o_dig_a.sample == $past(i_conv_a_sample))
        else $error("channel a routing wrong");

    chk_bind_a_from_b: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (!next_pd_a && digital_a_source_select) |=> o_dig_a.sample == $past(i_conv_b_sample))
        else $error("channel a from b wrong");

    // Valid travels with the sample of the bound converter.
    chk_valid_a_route: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        !next_pd_a |=> o_dig_a.valid
            == $past(digital_a_source_select ? i_conv_b_valid : i_conv_a_valid))
        else $error("channel a valid wrong");

    chk_valid_b_route: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        !next_pd_b |=> o_dig_b.valid
            == $past(digital_b_source_select ? i_conv_b_valid : i_conv_a_valid))
        else $error("channel b valid wrong");

    // Power-down of the bound converter reaches channel and link.
    chk_pd_follows: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (digital_a_source_select ? i_converter_b_powerdown : i_converter_a_powerdown)
            |=> o_link_a_powerdown && o_dig_a.powerdown && !o_dig_a.valid)
        else $error("channel a not powered down");

    chk_pd_b_follows: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (digital_b_source_select ? i_converter_b_powerdown : i_converter_a_powerdown)
            |=> o_link_b_powerdown && o_dig_b.powerdown && !o_dig_b.valid
                && o_dig_b.sample == '0)
        else $error("channel b not powered down");

    // A running bound converter keeps channel and link up.
    chk_pd_a_clear: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        !next_pd_a |=> !o_link_a_powerdown && !o_dig_a.powerdown)
        else $error("channel a powered down wrongly");

    chk_pd_b_clear: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        !next_pd_b |=> !o_link_b_powerdown && !o_dig_b.powerdown)
        else $error("channel b powered down wrongly");

    // Divisor writes land on the output two cycles later.
    chk_divisor_write: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_wr && hit_div_lo) |=> ##1 o_rational_divisor[7:0] == $past(i_wdata, 2))
        else $error("divisor write lost");

    chk_divisor_hi_write: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_wr && hit_div_hi) |=> ##1 o_rational_divisor[15:8] == $past(i_wdata, 2))
        else $error("divisor high write lost");

    // The divisor reads back as held, one cycle after the strobe.
    chk_divisor_read: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_rd && hit_div_lo) |=> o_rdata == $past(rational_divisor[7:0]))
        else $error("divisor read wrong");

    // The divisor leaves reset at zero.
    chk_divisor_reset: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        $fell(i_sys_rst) |-> rational_divisor == ddc_bind_pkg::rational_divisor_reset)
        else $error("divisor reset value wrong");

endmodule : ddc_bind_ctrl

`default_nettype wire

// file: hw/ddc_bind_pkg.sv
/*
 * Shared constants and types for the channel binding and oscillator sync control block.
 * Assumes a single 250 MHz system clock and a byte-wide register port.
 */
`default_nettype none

package ddc_bind_pkg;

    // Register byte offsets; each byte of the divisor has its own address.
    localparam logic [9:0] rational_divisor_lo_offset = 10'h217;
    localparam logic [9:0] rational_divisor_hi_offset = 10'h218;
    localparam logic [9:0] oscillator_sync_control_offset = 10'h219;
    localparam logic [9:0] channel_binding_offset = 10'h216;

    // Reset values.
    localparam logic [15:0] rational_divisor_reset = 16'h0000;
    localparam logic [7:0] oscillator_sync_control_reset = 8'h02;
    localparam logic [7:0] channel_binding_reset = 8'h02;

    // Field positions.
    localparam int sync_next_bit = 0;
    localparam int sync_ila_bit = 1;
    localparam int bind_a_bit = 0;
    localparam int bind_b_bit = 1;

    // Sample width of one converter channel.
    localparam int sample_width = 12;

    // Per digital channel output: sample, valid and power-down.
    typedef struct packed {
        logic [sample_width-1:0] sample;
        logic valid;
        logic powerdown;
    } dig_chan_t;

    // States of the next-SYSREF arming sequence.
    typedef enum logic [1:0] {
        arm_idle,
        arm_cleared,
        arm_armed
    } arm_state_t;

endpackage : ddc_bind_pkg

`default_nettype wire

// file: hw/sysref_arm.sv
/*
 * Arming logic for oscillator phase initialisation on the next SYSREF rising edge.
 * Assumes SYSREF and the write strobes are synchronous to the system clock.
 */
`default_nettype none

module sysref_arm (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // Writes of the arming bit.
    input wire logic i_wr_next,
    input wire logic i_wr_value,
    // SYSREF level.
    input wire logic i_sysref,
    // Phase initialisation strobe and armed state.
    output logic o_init,
    output logic o_armed
);

    ddc_bind_pkg::arm_state_t state;
    ddc_bind_pkg::arm_state_t next_state;
    logic sysref_d;
    wire logic sysref_rise;

    // A rising edge is SYSREF high after a low sample.
    assign sysref_rise = i_sysref & ~sysref_d;

    // A 0 then a 1 arms; the first rising edge afterwards fires and disarms.
    always_comb begin
        next_state = state;
        case (state)
            ddc_bind_pkg::arm_idle: begin
                if (i_wr_next && !i_wr_value) begin
                    next_state = ddc_bind_pkg::arm_cleared;
                end
            end
            ddc_bind_pkg::arm_cleared: begin
                if (i_wr_next && i_wr_value) begin
                    next_state = ddc_bind_pkg::arm_armed;
                end
            end
            ddc_bind_pkg::arm_armed: begin
                if (i_wr_next && !i_wr_value) begin
                    next_state = ddc_bind_pkg::arm_cleared;
                end else if (sysref_rise) begin
                    next_state = ddc_bind_pkg::arm_idle;
                end
            end
            default: begin
                next_state = ddc_bind_pkg::arm_idle;
            end
        endcase
    end

    // State, edge history and the one-cycle initialisation strobe.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            state <= ddc_bind_pkg::arm_idle;
            sysref_d <= 1'b0;
            o_init <= 1'b0;
            o_armed <= 1'b0;
        end else begin
            state <= next_state;
            sysref_d <= i_sysref;
            o_init <= (state == ddc_bind_pkg::arm_armed) && sysref_rise
                && !(i_wr_next && !i_wr_value);
            o_armed <= (next_state == ddc_bind_pkg::arm_armed);
        end
    end

    // Once fired, no further strobe until re-armed.
    chk_init_needs_arm: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        o_init |-> $past(state) == ddc_bind_pkg::arm_armed)
        else $error("phase init without arming");

    // Armed with an edge and no write gives a strobe next cycle.
    chk_armed_fires: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (state == ddc_bind_pkg::arm_armed && sysref_rise && !i_wr_next) |=> o_init)
        else $error("armed sysref edge missed");

endmodule : sysref_arm

`default_nettype wire

// file: sim/sync_source.sv
/*
 * Behavioural SYSREF source and link receiver timing marks.
 * Assumes requests arrive as one-cycle strobes on the system clock.
 */
`default_nettype none

module sync_source (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // Requests from the bench.
    input wire logic i_req_sysref,
    input wire logic i_req_lmfc,
    // Timing marks towards the block.
    output logic o_sysref,
    output logic o_lmfc_ila_start
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] hold;

    // SYSREF idles low and pulses for two cycles only on request.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            hold <= 2'h0;
            o_sysref <= 1'b0;
            o_lmfc_ila_start <= 1'b0;
        end else begin
            o_lmfc_ila_start <= i_req_lmfc;
            hold <= i_req_sysref ? 2'h2 : (hold != 2'h0 ? hold - 2'h1 : 2'h0);
            o_sysref <= i_req_sysref || (hold > 2'h1);
        end
    end
endmodule : sync_source

`default_nettype wire

// file: sim/test_ddc_bind_ctrl.sv
/*
 * Self-checking bench for the binding and oscillator sync control block.
 * Assumes the design package and the SYSREF source model are compiled first.
 */
`default_nettype none

module test_ddc_bind_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rq_s = 1'b0, rq_l = 1'b0;
    logic [9:0] addr = 10'h0;
    logic [7:0] wdata = 8'h0;
    logic [7:0] rdata;
    logic [11:0] sa = 12'h5a1, sb = 12'ha5e;
    logic pd_a = 1'b0, pd_b = 1'b0, link_en = 1'b1, sysref, lmfc, init, lpa, lpb;
    logic va = 1'b1, vb = 1'b0;
    logic [15:0] rdiv;
    ddc_bind_pkg::dig_chan_t da, db;
    int fails = 0, check_count = 0;

    // The clock toggles every 2 ns, a period of 4 ns.
    always #2 clk = ~clk;

    sync_source i_src (.i_sys_clk(clk), .i_sys_rst(rst), .i_req_sysref(rq_s),
        .i_req_lmfc(rq_l), .o_sysref(sysref), .o_lmfc_ila_start(lmfc));

    ddc_bind_ctrl i_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_conv_a_sample(sa), .i_conv_a_valid(va),
        .i_conv_b_sample(sb), .i_conv_b_valid(vb), .i_converter_a_powerdown(pd_a),
        .i_converter_b_powerdown(pd_b), .i_serial_link_enable(link_en),
        .i_lmfc_ila_start(lmfc), .i_sysref(sysref), .o_dig_a(da), .o_dig_b(db),
        .o_link_a_powerdown(lpa), .o_link_b_powerdown(lpb), .o_rational_divisor(rdiv),
        .o_phase_init(init));

    // Compares one value and counts the outcome.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // One write cycle on the register port.
    task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
        @(posedge clk) wr <= 1'b0;
    endtask : reg_wr

    // One read cycle; the data is looked at in the following cycle only.
    task automatic reg_rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge clk) begin addr <= a; rd <= 1'b1; end
        @(posedge clk) rd <= 1'b0;
        #1 chk({8'h0, rdata}, {8'h0, exp});
    endtask : reg_rd

    // Requests a SYSREF pulse or a lane-alignment mark and times the init pulse.
    task automatic fire(input logic s, input logic [15:0] exp_n);
        logic [15:0] first, hits;
        first = 16'h0;
        hits = 16'h0;
        @(posedge clk) begin rq_s <= s; rq_l <= !s; end
        @(posedge clk) begin rq_s <= 1'b0; rq_l <= 1'b0; end
        for (int k = 1; k <= 6; k++) begin
            @(posedge clk);
            #1 if (init === 1'b1) begin
                hits++;
                if (first == 16'h0) first = 16'(k);
            end
        end
        chk(first, exp_n);
        chk(hits, {15'h0, exp_n != 16'h0});
    endtask : fire

    // Reset values, divisor bytes and an unmapped place.
    task automatic test_regs;
        reg_rd(10'h216, 8'h02);
        reg_rd(10'h217, 8'h00);
        reg_rd(10'h218, 8'h00);
        reg_rd(10'h219, 8'h02);
        reg_wr(10'h217, 8'h34);
        reg_wr(10'h218, 8'h12);
        reg_wr(10'h000, 8'hff);
        @(posedge clk) #1 chk(rdiv, 16'h1234);
        reg_rd(10'h218, 8'h12);
        reg_rd(10'h000, 8'h00);
        $display("register test done");
    endtask : test_regs

    // Every binding against every power-down pattern.
    task automatic test_bind;
        logic [1:0] v, p;
        logic qa, qb;
        logic [15:0] ea, eb;
        @(posedge clk) link_en <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            v = 2'(i >> 2);
            p = 2'(i);
            reg_wr(10'h216, {6'h0, v});
            @(posedge clk) begin pd_a <= p[0]; pd_b <= p[1]; end
            repeat (3) @(posedge clk);
            #1 qa = p[v[0]];
            qb = p[v[1]];
            ea = qa ? 16'h1 : {2'h0, (v[0] ? sb : sa), (v[0] ? vb : va), 1'b0};
            eb = qb ? 16'h1 : {2'h0, (v[1] ? sb : sa), (v[1] ? vb : va), 1'b0};
            chk({2'h0, da}, ea);
            chk({2'h0, db}, eb);
            chk({14'h0, lpa, lpb}, {14'h0, qa, qb});
        end
        @(posedge clk) begin pd_a <= 1'b0; pd_b <= 1'b0; end
        reg_wr(10'h216, 8'h02);
        link_en <= 1'b1;
        $display("binding test done");
    endtask : test_bind

    // Phase init from the lane-alignment mark, then the SYSREF arming sequence.
    task automatic test_sync;
        fire(1'b0, 16'h1);
        reg_wr(10'h219, 8'h01);
        fire(1'b1, 16'h0);
        fire(1'b0, 16'h0);
        reg_wr(10'h219, 8'h00);
        reg_wr(10'h219, 8'h01);
        fire(1'b1, 16'h2);
        fire(1'b1, 16'h0);
        reg_wr(10'h219, 8'h00);
        reg_wr(10'h219, 8'h01);
        fire(1'b1, 16'h2);
        $display("sync test done");
    endtask : test_sync

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // Reset for six cycles, then run the scenarios.
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        test_regs();
        test_bind();
        test_sync();
        wrap_up();
    end
endmodule : test_ddc_bind_ctrl

`default_nettype wire
